// File: dv/carssx_core_sva.sv
// Concurrent checks on the datapath's instruction, sleep and register ports
`timescale 1ns/10ps
module carssx_core_sva
   import carssx_pkg::*;
(
   input wire logic clk_sys, // clock
   input wire logic rstn, // reset, active low
   input wire logic op_valid, // instruction offered
   input wire carssx_op_type op_code, // instruction
   input wire logic [FILE_AW-1:0] op_file_addr, // file address
   input wire logic op_dest, // destination select
   input wire logic [DATA_W-1:0] op_literal, // literal
   input wire logic op_ready, // ready
   input wire logic op_done, // done pulse
   input wire logic wake_req, // wake-up
   input wire logic asleep, // sleeping
   input wire logic [BUS_AW-1:0] bus_addr, // register address
   input wire logic [DATA_W-1:0] bus_wdata, // write data
   input wire logic bus_wr, // write strobe
   input wire logic bus_rd, // read strobe
   input wire logic [DATA_W-1:0] bus_rdata // read data
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);
   logic take;
   logic [15:0] sleep_len;
   assign take = op_valid && op_ready;

   // Cycles spent asleep; the watchdog can end sleep only once this reaches its top value
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         sleep_len <= 16'h0000;
      end
      else if (!asleep)
      begin
         sleep_len <= 16'h0000;
      end
      else if (sleep_len != 16'hffff)
      begin
         sleep_len <= sleep_len + 16'h0001;
      end
   end

   a_exec_done: assert property (take && op_code != op_sleep |=> !op_ready ##1 (op_done && op_ready))
      else $error("instruction did not finish two cycles after accept");
   a_done_single: assert property (op_done |=> !op_done)
      else $error("done pulse longer than one cycle");
   a_done_cause: assert property (op_done |-> !$past(op_ready) && $past(op_ready, 2))
      else $error("done pulse without an executed instruction");
   a_sleep_enter: assert property (take && op_code == op_sleep |=> asleep && !op_ready && !op_done)
      else $error("sleep not entered after sleep instruction");
   a_sleep_stays: assert property (asleep && !wake_req && sleep_len != 16'hffff |=> asleep)
      else $error("sleep left without a wake-up");
   a_sleep_refuse: assert property (asleep |-> !op_ready && !op_done)
      else $error("instruction activity while asleep");
   a_wake_ready: assert property (asleep && wake_req |=> !asleep && op_ready)
      else $error("wake-up did not restore ready");
   a_unmapped_zero: assert property (bus_rd && bus_addr inside {[8'h04:8'h7f]} |=> bus_rdata == 8'h00)
      else $error("unmapped read returned nonzero data");

   c_subtract: cover property (take && op_code == op_subtract_acc_from_file);
   c_sleep: cover property (take && op_code == op_sleep);
   c_wake: cover property (asleep && wake_req);
   c_timeout_wake: cover property (asleep && !wake_req ##1 !asleep);
endmodule // carssx_core_sva

bind carssx_core carssx_core_sva chk (.clk_sys(clk_sys), .rstn(rstn), .op_valid(op_valid),
   .op_code(op_code), .op_file_addr(op_file_addr), .op_dest(op_dest), .op_literal(op_literal),
   .op_ready(op_ready), .op_done(op_done), .wake_req(wake_req), .asleep(asleep),
   .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
   .bus_rdata(bus_rdata));

// File: dv/core_alu_rotate_sub_swap_xor_test.sv
// Self-checking bench: instruction table against a reference model, then sleep and wake
`timescale 1ns/10ps
module core_alu_rotate_sub_swap_xor_test;
   import carssx_pkg::*;
   typedef struct {carssx_op_type op; logic [6:0] fa; logic d; logic [7:0] lit;} carssx_row_type;
   logic clk_sys, rstn, op_valid, op_dest, wake_req, bus_wr, bus_rd, op_ready, op_done, asleep;
   carssx_op_type op_code;
   logic [6:0] op_file_addr;
   logic [7:0] op_literal, bus_addr, bus_wdata, bus_rdata, rd_val, f, res;
   logic [7:0] m_acc, m_file [128];
   logic m_c, m_dc, m_z;
   int n_fail, n_tests, cycles;
   carssx_row_type rows [11];

   carssx_core DUT (.clk_sys(clk_sys), .rstn(rstn), .op_valid(op_valid), .op_code(op_code),
      .op_file_addr(op_file_addr), .op_dest(op_dest), .op_literal(op_literal),
      .op_ready(op_ready), .op_done(op_done), .wake_req(wake_req), .asleep(asleep),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_rdata(bus_rdata));

   initial
   begin
      clk_sys = 0;
      forever #10 clk_sys = ~clk_sys;
   end

   task final_report;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Ceiling above the roughly 66,000 cycles needed, nearly all of them the watchdog wait
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (cycles == 80000)
      begin
         n_fail++;
         final_report;
      end
   end

   task check(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge clk_sys);
      bus_wr <= 1'b0;
   endtask

   task rd(input logic [7:0] a);
      @(posedge clk_sys);
      bus_rd <= 1'b1;
      bus_addr <= a;
      @(posedge clk_sys);
      bus_rd <= 1'b0;
      #1 rd_val = bus_rdata;
   endtask

   // Offer one instruction; it is taken at the next edge since the core is idle
   task issue(input carssx_op_type op, input logic [6:0] fa, input logic d, input logic [7:0] k);
      @(posedge clk_sys);
      op_valid <= 1'b1;
      op_code <= op;
      op_file_addr <= fa;
      op_dest <= d;
      op_literal <= k;
      @(posedge clk_sys);
      op_valid <= 1'b0;
      if (op != op_sleep)
      begin
         @(posedge clk_sys);
         #1 check("op_done", 8'h01, {7'h00, op_done});
      end
   endtask

   initial
   begin
      {rstn, op_valid, op_dest, wake_req, bus_wr, bus_rd} = '0;
      op_code = op_rotate_right_via_carry;
      {op_file_addr, op_literal, bus_addr, bus_wdata} = '0;
      {n_fail, n_tests, cycles} = '0;
      rows = '{'{op_subtract_acc_from_file, 7'h00, 1'b0, 8'h00},
         '{op_xor_literal_into_acc, 7'h00, 1'b1, 8'hff},
         '{op_subtract_acc_from_file, 7'h05, 1'b1, 8'h00},
         '{op_rotate_right_via_carry, 7'h7f, 1'b1, 8'h00},
         '{op_rotate_right_via_carry, 7'h7f, 1'b0, 8'h00},
         '{op_nibble_exchange, 7'h00, 1'b1, 8'h00},
         '{op_nibble_exchange, 7'h7f, 1'b0, 8'h00},
         '{op_xor_acc_with_file, 7'h05, 1'b1, 8'h00},
         '{op_subtract_acc_from_file, 7'h05, 1'b1, 8'h00},
         '{op_xor_acc_with_file, 7'h05, 1'b0, 8'h00},
         '{op_xor_literal_into_acc, 7'h00, 1'b0, 8'h15}};
      repeat (16) @(posedge clk_sys);
      rstn <= 1'b1;
      rd(STATUS_OFS);
      check("status reset", 8'h18, rd_val);
      rd(ACC_OFS);
      check("acc reset", 8'h00, rd_val);
      rd(8'h04);
      check("unmapped low", 8'h00, rd_val);
      wr(8'h7f, 8'ha5);
      rd(8'h7f);
      check("unmapped high", 8'h00, rd_val);
      // Upper status bits are read-only, so only the flags take the write
      wr(STATUS_OFS, 8'hff);
      rd(STATUS_OFS);
      check("status write", 8'h1f, rd_val);
      {m_c, m_dc, m_z} = 3'b111;
      m_acc = 8'h3c;
      wr(ACC_OFS, m_acc);
      m_file[0] = 8'h3c;
      m_file[5] = 8'h10;
      m_file[127] = 8'h81;
      foreach (m_file[i])
         if (i == 0 || i == 5 || i == 127)
            wr(8'h80 | 8'(i), m_file[i]);
      foreach (rows[i])
      begin
         f = m_file[rows[i].fa];
         case (rows[i].op)
            op_rotate_right_via_carry:
            begin
               res = {m_c, f[7:1]};
               m_c = f[0];
            end
            op_subtract_acc_from_file:
            begin
               res = f - m_acc;
               m_c = f >= m_acc;
               m_dc = f[3:0] >= m_acc[3:0];
               m_z = res == 8'h00;
            end
            op_nibble_exchange: res = {f[3:0], f[7:4]};
            op_xor_literal_into_acc:
            begin
               res = m_acc ^ rows[i].lit;
               m_z = res == 8'h00;
            end
            default:
            begin
               res = m_acc ^ f;
               m_z = res == 8'h00;
            end
         endcase
         if (rows[i].d && rows[i].op != op_xor_literal_into_acc)
            m_file[rows[i].fa] = res;
         else
            m_acc = res;
         issue(rows[i].op, rows[i].fa, rows[i].d, rows[i].lit);
         rd(ACC_OFS);
         check("acc", m_acc, rd_val);
         rd(STATUS_OFS);
         check("flags", {5'h00, m_z, m_dc, m_c}, {5'h00, rd_val[2:0]});
         rd(8'h80 | {1'b0, rows[i].fa});
         check("file", m_file[rows[i].fa], rd_val);
      end
      issue(op_sleep, 7'h00, 1'b0, 8'h00);
      #1 check("asleep", 8'h01, {7'h00, asleep});
      // An instruction held while asleep must be refused and leave the accumulator alone
      @(posedge clk_sys);
      op_valid <= 1'b1;
      op_code <= op_xor_literal_into_acc;
      op_literal <= 8'h5a;
      repeat (4) @(posedge clk_sys);
      op_valid <= 1'b0;
      rd(STATUS_OFS);
      check("status asleep", {5'h05, m_z, m_dc, m_c}, rd_val);
      rd(WDOG_OFS);
      check("watchdog", 8'h00, rd_val);
      rd(ACC_OFS);
      check("acc asleep", m_acc, rd_val);
      @(posedge clk_sys);
      wake_req <= 1'b1;
      @(posedge clk_sys);
      wake_req <= 1'b0;
      #1 check("ready after wake", 8'h01, {7'h00, op_ready});
      // Only reset brings the power-down bit back
      @(posedge clk_sys);
      rstn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      rd(STATUS_OFS);
      check("status after reset", 8'h18, rd_val);
      // With no wake-up request, the watchdog ends sleep after 65536 cycles
      issue(op_sleep, 7'h00, 1'b0, 8'h00);
      repeat (65535) @(posedge clk_sys);
      #1 check("asleep before time-out", 8'h01, {7'h00, asleep});
      @(posedge clk_sys);
      #1 check("asleep after time-out", 8'h00, {7'h00, asleep});
      rd(STATUS_OFS);
      check("status after time-out", 8'h00, rd_val);
      final_report;
   end
endmodule // core_alu_rotate_sub_swap_xor_test

// File: hdl/carssx_core.sv
// Execution datapath for rotate, subtract, nibble swap, xor and sleep
`timescale 1ns/10ps
module carssx_core
   import carssx_pkg::*;
(
   input wire logic clk_sys, // system clock, 50 MHz
   input wire logic rstn, // asynchronous reset, active low
   input wire logic op_valid, // instruction presented
   input wire carssx_op_type op_code, // instruction to execute
   input wire logic [FILE_AW-1:0] op_file_addr, // file register address
   input wire logic op_dest, // destination select
   input wire logic [DATA_W-1:0] op_literal, // immediate operand
   output logic op_ready, // instruction can be taken this cycle
   output logic op_done, // one-cycle pulse when a result is written
   input wire logic wake_req, // external wake-up event
   output logic asleep, // oscillator halt request, high while sleeping
   input wire logic [BUS_AW-1:0] bus_addr, // register address
   input wire logic [DATA_W-1:0] bus_wdata, // register write data
   input wire logic bus_wr, // write strobe
   input wire logic bus_rd, // read strobe
   output logic [DATA_W-1:0] bus_rdata // read data, valid the cycle after bus_rd
);

   carssx_mem_if mem_bus ();

   carssx_file_mem u_file_mem (
      .clk_sys (clk_sys),
      .rstn (rstn),
      .port (mem_bus.mem)
   );

   carssx_state_type state;
   carssx_state_type next_state;
   carssx_op_type op_q;
   carssx_op_type next_op_q;
   logic [FILE_AW-1:0] addr_q;
   logic [FILE_AW-1:0] next_addr_q;
   logic dest_q;
   logic next_dest_q;
   logic [DATA_W-1:0] lit_q;
   logic [DATA_W-1:0] next_lit_q;
   logic [DATA_W-1:0] acc;
   logic [DATA_W-1:0] next_acc;
   logic carry;
   logic next_carry;
   logic half_byte_overflow_bit;
   logic next_half_byte_overflow_bit;
   logic zero;
   logic next_zero;
   logic watchdog_expiry_bit;
   logic next_watchdog_expiry_bit;
   logic power_down_bit;
   logic next_power_down_bit;
   logic [DATA_W-1:0] watchdog_counter;
   logic [DATA_W-1:0] next_watchdog_counter;
   logic [DATA_W-1:0] presc;
   logic [DATA_W-1:0] next_presc;
   logic done;
   logic next_done;
   logic rd_file_q;
   logic next_rd_file_q;
   logic [DATA_W-1:0] rd_reg_q;
   logic [DATA_W-1:0] next_rd_reg_q;

   // Datapath results
   logic [DATA_W-1:0] file_val;
   logic [DATA_W-1:0] result;
   logic [DATA_W:0] diff;
   logic [DATA_W/2:0] diff_low;
   logic res_carry;
   logic res_half;
   logic to_file;
   logic upd_carry;
   logic upd_half;
   logic upd_zero;
   logic timeout;
   logic bus_file;
   logic [DATA_W-1:0] status_view;

   assign file_val = mem_bus.rd_data_a;
   assign bus_file = bus_addr[FILE_SEL_BIT];

   // Operand A is read continuously at the offered address, so the data is
   // ready in the cycle after the instruction is taken.
   assign mem_bus.rd_addr_a = op_file_addr;
   assign mem_bus.rd_addr_b = bus_addr[FILE_AW-1:0];

   always_comb
   begin
      diff = {1'b0, file_val} + {1'b0, ~acc} + {{DATA_W{1'b0}}, 1'b1};
      diff_low = {1'b0, file_val[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
      result = file_val;
      res_carry = carry;
      res_half = half_byte_overflow_bit;
      to_file = (dest_q == DEST_FILE);
      upd_carry = 1'b0;
      upd_half = 1'b0;
      upd_zero = 1'b0;
      unique case (op_q)
         op_rotate_right_via_carry:
         begin
            result = {carry, file_val[DATA_W-1:1]};
            res_carry = file_val[0];
            upd_carry = 1'b1;
         end
         op_subtract_acc_from_file:
         begin
            result = diff[DATA_W-1:0];
            res_carry = diff[DATA_W];
            res_half = diff_low[DATA_W/2];
            upd_carry = 1'b1;
            upd_half = 1'b1;
            upd_zero = 1'b1;
         end
         op_nibble_exchange:
         begin
            result = {file_val[3:0], file_val[7:4]};
         end
         op_xor_literal_into_acc:
         begin
            result = acc ^ lit_q;
            to_file = 1'b0;
            upd_zero = 1'b1;
         end
         op_xor_acc_with_file:
         begin
            result = acc ^ file_val;
            upd_zero = 1'b1;
         end
         op_sleep:
         begin
            to_file = 1'b0;
         end
      endcase
   end

   // Watchdog overflows after 256 prescaler wraps of 256 clocks
   assign timeout = (presc == COUNT_LAST) && (watchdog_counter == COUNT_LAST);

   always_comb
   begin
      next_state = state;
      next_op_q = op_q;
      next_addr_q = addr_q;
      next_dest_q = dest_q;
      next_lit_q = lit_q;
      next_acc = acc;
      next_carry = carry;
      next_half_byte_overflow_bit = half_byte_overflow_bit;
      next_zero = zero;
      next_watchdog_expiry_bit = watchdog_expiry_bit;
      next_power_down_bit = power_down_bit;
      next_presc = presc + 8'h01;
      next_watchdog_counter = watchdog_counter;
      next_done = 1'b0;
      mem_bus.wr_en = 1'b0;
      mem_bus.wr_addr = bus_addr[FILE_AW-1:0];
      mem_bus.wr_data = bus_wdata;
      if (presc == COUNT_LAST)
      begin
         next_watchdog_counter = watchdog_counter + 8'h01;
      end
      if (timeout)
      begin
         next_watchdog_expiry_bit = 1'b0;
      end
      // Software writes come first so that hardware updates below win
      if (bus_wr)
      begin
         if (bus_file)
         begin
            mem_bus.wr_en = 1'b1;
         end
         else if (bus_addr == ACC_OFS)
         begin
            next_acc = bus_wdata;
         end
         else if (bus_addr == STATUS_OFS)
         begin
            next_carry = bus_wdata[ST_CARRY];
            next_half_byte_overflow_bit = bus_wdata[ST_HALF];
            next_zero = bus_wdata[ST_ZERO];
         end
      end
      unique case (state)
         st_idle:
         begin
            if (op_valid)
            begin
               next_op_q = op_code;
               next_addr_q = op_file_addr;
               next_dest_q = op_dest;
               next_lit_q = op_literal;
               if (op_code == op_sleep)
               begin
                  next_watchdog_counter = WDOG_CLEAR;
                  next_presc = PRESC_CLEAR;
                  next_watchdog_expiry_bit = 1'b1;
                  next_power_down_bit = 1'b0;
                  next_state = st_sleep;
               end
               else
               begin
                  next_state = st_exec;
               end
            end
         end
         st_exec:
         begin
            next_done = 1'b1;
            next_state = st_idle;
            if (to_file)
            begin
               // A bus write to the file in this cycle is dropped
               mem_bus.wr_en = 1'b1;
               mem_bus.wr_addr = addr_q;
               mem_bus.wr_data = result;
            end
            else
            begin
               next_acc = result;
            end
            if (upd_carry)
            begin
               next_carry = res_carry;
            end
            if (upd_half)
            begin
               next_half_byte_overflow_bit = res_half;
            end
            if (upd_zero)
            begin
               next_zero = (result == ZERO_BYTE);
            end
         end
         st_sleep:
         begin
            // Watchdog keeps counting on its own so a time-out can end sleep
            if (wake_req || timeout)
            begin
               next_state = st_idle;
            end
         end
         default:
         begin
            next_state = st_idle;
         end
      endcase
   end

   always_comb
   begin
      status_view = ZERO_BYTE;
      status_view[ST_CARRY] = carry;
      status_view[ST_HALF] = half_byte_overflow_bit;
      status_view[ST_ZERO] = zero;
      status_view[ST_EXPIRY] = watchdog_expiry_bit;
      status_view[ST_PDOWN] = power_down_bit;
      status_view[ST_ASLEEP] = (state == st_sleep);
      next_rd_file_q = bus_rd && bus_file;
      next_rd_reg_q = ZERO_BYTE;
      if (bus_rd && !bus_file)
      begin
         unique case (bus_addr)
            ACC_OFS: next_rd_reg_q = acc;
            STATUS_OFS: next_rd_reg_q = status_view;
            WDOG_OFS: next_rd_reg_q = watchdog_counter;
            PRESC_OFS: next_rd_reg_q = presc;
            default: next_rd_reg_q = ZERO_BYTE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         state <= st_idle;
         op_q <= op_rotate_right_via_carry;
         addr_q <= '0;
         dest_q <= DEST_ACC;
         lit_q <= ZERO_BYTE;
         acc <= ACC_RST;
         carry <= FLAG_RST;
         half_byte_overflow_bit <= FLAG_RST;
         zero <= FLAG_RST;
         watchdog_expiry_bit <= EXPIRY_RST;
         power_down_bit <= PDOWN_RST;
         watchdog_counter <= WDOG_CLEAR;
         presc <= PRESC_CLEAR;
         done <= 1'b0;
         rd_file_q <= 1'b0;
         rd_reg_q <= RDATA_RST;
      end
      else
      begin
         state <= next_state;
         op_q <= next_op_q;
         addr_q <= next_addr_q;
         dest_q <= next_dest_q;
         lit_q <= next_lit_q;
         acc <= next_acc;
         carry <= next_carry;
         half_byte_overflow_bit <= next_half_byte_overflow_bit;
         zero <= next_zero;
         watchdog_expiry_bit <= next_watchdog_expiry_bit;
         power_down_bit <= next_power_down_bit;
         watchdog_counter <= next_watchdog_counter;
         presc <= next_presc;
         done <= next_done;
         rd_file_q <= next_rd_file_q;
         rd_reg_q <= next_rd_reg_q;
      end
   end

   assign op_ready = (state == st_idle);
   assign op_done = done;
   assign asleep = (state == st_sleep);
   assign bus_rdata = rd_file_q ? mem_bus.rd_data_b : rd_reg_q;

endmodule // carssx_core

// File: hdl/carssx_file_mem.sv
// File register memory: one write port, two registered read ports
`timescale 1ns/10ps
module carssx_file_mem
   import carssx_pkg::*;
(
   input wire logic clk_sys, // system clock
   input wire logic rstn, // asynchronous reset, active low
   carssx_mem_if.mem port // read and write ports
);

   logic [DATA_W-1:0] cells [FILE_DEPTH];
   logic [DATA_W-1:0] next_rd_data_a;
   logic [DATA_W-1:0] next_rd_data_b;

   always_comb
   begin
      next_rd_data_a = cells[port.rd_addr_a];
      next_rd_data_b = cells[port.rd_addr_b];
   end

   // Storage has no reset; contents are undefined until written
   always_ff @(posedge clk_sys)
   begin
      if (port.wr_en)
      begin
         cells[port.wr_addr] <= port.wr_data;
      end
   end

   // Read data is registered; a same-cycle write returns the old contents
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         port.rd_data_a <= RDATA_RST;
         port.rd_data_b <= RDATA_RST;
      end
      else
      begin
         port.rd_data_a <= next_rd_data_a;
         port.rd_data_b <= next_rd_data_b;
      end
   end

endmodule // carssx_file_mem

// File: pkg/carssx_mem_if.sv
// Connection between the datapath and its file register memory
`timescale 1ns/10ps
interface carssx_mem_if;
   import carssx_pkg::*;
   logic [FILE_AW-1:0] rd_addr_a;
   logic [DATA_W-1:0] rd_data_a;
   logic [FILE_AW-1:0] rd_addr_b;
   logic [DATA_W-1:0] rd_data_b;
   logic wr_en;
   logic [FILE_AW-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;

   modport core (output rd_addr_a, input rd_data_a, output rd_addr_b, input rd_data_b,
                 output wr_en, output wr_addr, output wr_data);
   modport mem (input rd_addr_a, output rd_data_a, input rd_addr_b, output rd_data_b,
                input wr_en, input wr_addr, input wr_data);
endinterface

// File: pkg/carssx_pkg.sv
// Constants and types shared by the rotate/subtract/swap/xor datapath and its file memory
package carssx_pkg;

   localparam int DATA_W = 8;
   localparam int FILE_AW = 7;
   localparam int BUS_AW = 8;
   localparam int FILE_DEPTH = 128;

   // Register offsets on the plain register port; bit 7 set selects the file memory
   localparam logic [7:0] ACC_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h01;
   localparam logic [7:0] WDOG_OFS = 8'h02;
   localparam logic [7:0] PRESC_OFS = 8'h03;
   localparam int FILE_SEL_BIT = 7;

   // Status field positions
   localparam int ST_CARRY = 0;
   localparam int ST_HALF = 1;
   localparam int ST_ZERO = 2;
   localparam int ST_EXPIRY = 3;
   localparam int ST_PDOWN = 4;
   localparam int ST_ASLEEP = 5;

   // Reset and clear values
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [7:0] RDATA_RST = 8'h00;
   localparam logic [7:0] WDOG_CLEAR = 8'h00;
   localparam logic [7:0] PRESC_CLEAR = 8'h00;
   localparam logic [7:0] COUNT_LAST = 8'hff;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic FLAG_RST = 1'b0;
   localparam logic EXPIRY_RST = 1'b1;
   localparam logic PDOWN_RST = 1'b1;

   // Destination select
   localparam logic DEST_ACC = 1'b0;
   localparam logic DEST_FILE = 1'b1;

   typedef enum logic [2:0] {
      op_rotate_right_via_carry = 3'h0,
      op_subtract_acc_from_file = 3'h1,
      op_nibble_exchange = 3'h2,
      op_xor_literal_into_acc = 3'h3,
      op_xor_acc_with_file = 3'h4,
      op_sleep = 3'h5
   } carssx_op_type;

   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_exec = 2'b01,
      st_sleep = 2'b10
   } carssx_state_type;

endpackage
